// *** src/capture_compare_unit.sv ***
// Capture/compare unit with its free-running timer and AXI4-Lite registers
// Assumes one clock, synchronous reset and synchronous pin input
//
// Notes on behaviour
// - Capture copies the whole 16-bit timer count into the capture register.
// - Mode picks capture on falling, rising, 4th rising or 16th rising edge.
// - Each capture sets the unit flag; only software clears it.
// - A new capture overwrites an unread earlier value.
// - With the pin an output, a data write changing its level captures.
// - Prescaler count clears whenever the unit is off or not capturing.
// - Changing prescale directly keeps the count; software writes zero first.
// - Compare match drives the pin high, low or leaves it per mode.
// - Every compare match sets the unit flag.
// - Writing zero to the control register forces the compare latch low.
// - Software interrupt compare mode only sets the flag on a match.
// - Special trigger mode resets the timer on a match.
// - Special trigger mode emits a conversion start pulse on a match.
// - Unit enable bit gates the unit flag onto the interrupt.
// - Peripheral gate bit must be set for the interrupt to pass.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module capture_compare_unit
  import ccu_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_sys_rst,
  input  wire logic     i_ce,
  input  wire axi_req_t i_axi,
  output axi_rsp_t      o_axi,
  input  wire logic     i_pin_in,
  output logic          o_pin_out,
  output logic          o_pin_oe_n,
  output logic          o_irq,
  output logic          o_adc_trigger
);

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_held;
    logic [7:0]  aw_idx;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        global_en;
    logic        periph_gate;
    logic        flag;
    logic        unit_en;
    logic [15:0] timer;
    logic [5:0]  timer_ctl;
    logic [15:0] cc_value;
    logic [5:0]  cc_ctl;
    logic [7:0]  port_dir;
    logic [7:0]  port_data;
    logic        cmp_latch;
    logic        match_prev;
    logic        pin_out;
    logic        pin_oe_n;
    logic        irq;
    logic        trigger;
  } unit_state_t;

  unit_state_t state;
  unit_state_t next_state;

  logic        is_capture;
  logic        is_compare;
  logic [3:0]  mode;
  logic        pin_level;
  logic        pin_rise;
  logic        pin_fall;
  logic        cap_evt;
  logic        match_evt;
  logic        bus_wr;
  logic        wr_ctl_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode helpers
  function automatic logic mapped(input logic [7:0] idx);
    unique case (idx)
      IDX_PORT_C_DATA, IDX_INT_CONTROL, IDX_PERIPH_FLAGS, IDX_TIMER_LOW,
      IDX_TIMER_HIGH, IDX_TIMER_CONTROL, IDX_CC_LOW, IDX_CC_HIGH,
      IDX_CC_CONTROL, IDX_PORT_C_DIR, IDX_PERIPH_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic [7:0] read_byte(input logic [7:0]  idx,
                                           input unit_state_t s);
    read_byte = 8'h00;
    unique case (idx)
      IDX_PORT_C_DATA:   read_byte = s.port_data;
      IDX_INT_CONTROL:   read_byte = {s.global_en, s.periph_gate, 6'h00};
      IDX_PERIPH_FLAGS:  read_byte = {5'h00, s.flag, 2'h0};
      IDX_TIMER_LOW:     read_byte = s.timer[7:0];
      IDX_TIMER_HIGH:    read_byte = s.timer[15:8];
      IDX_TIMER_CONTROL: read_byte = {2'h0, s.timer_ctl};
      IDX_CC_LOW:        read_byte = s.cc_value[7:0];
      IDX_CC_HIGH:       read_byte = s.cc_value[15:8];
      IDX_CC_CONTROL:    read_byte = {2'h0, s.cc_ctl};
      IDX_PORT_C_DIR:    read_byte = s.port_dir;
      IDX_PERIPH_IRQ_EN: read_byte = {5'h00, s.unit_en, 2'h0};
      default:           read_byte = 8'h00;
    endcase
  endfunction : read_byte

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and pin level seen by the capture logic
  assign mode       = state.cc_ctl[3:0];
  assign is_capture = mode[3:2] == 2'h1;
  assign is_compare = mode[3:2] == 2'h2;
  assign pin_level  = state.pin_oe_n ? i_pin_in : state.pin_out;
  assign match_evt  = is_compare && state.timer == state.cc_value &&
                      !state.match_prev;
  assign bus_wr     = state.aw_held && state.w_held && !state.bvalid &&
                      state.wstrb[0] && mapped(state.aw_idx);
  assign wr_ctl_zero = bus_wr && state.aw_idx == IDX_CC_CONTROL &&
                       state.wdata[5:0] == 6'h00;

  ccu_edge_detect u_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_level   (pin_level),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  ccu_prescaler u_prescaler (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (is_capture),
    .i_sel     (capture_sel_t'(mode[1:0])),
    .i_rise    (pin_rise),
    .i_fall    (pin_fall),
    .o_event   (cap_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus, timer, capture, compare, interrupt, pin
  always_comb
  begin
    next_state = state;
    if (i_ce)
    begin
      // Write address and data channels, taken in either order
      if (i_axi.awvalid && state.awready)
      begin
        next_state.aw_held = 1'b1;
        next_state.aw_idx  = i_axi.awaddr[9:2];
      end
      if (i_axi.wvalid && state.wready)
      begin
        next_state.w_held = 1'b1;
        next_state.wdata  = i_axi.wdata;
        next_state.wstrb  = i_axi.wstrb;
      end
      if (state.bvalid && i_axi.bready)
      begin
        next_state.bvalid = 1'b0;
      end

      // Free-running timer
      if (state.timer_ctl[TIMER_ON_BIT])
      begin
        next_state.timer = state.timer + 16'h0001;
      end

      // Register write once both halves are held
      if (state.aw_held && state.w_held && !state.bvalid)
      begin
        next_state.aw_held = 1'b0;
        next_state.w_held  = 1'b0;
        next_state.bvalid  = 1'b1;
        next_state.bresp   = mapped(state.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bus_wr)
      begin
        unique case (state.aw_idx)
          IDX_PORT_C_DATA:   next_state.port_data = state.wdata[7:0];
          IDX_INT_CONTROL:
          begin
            next_state.global_en   = state.wdata[GLOBAL_IRQ_BIT];
            next_state.periph_gate = state.wdata[PERIPH_GATE_BIT];
          end
          IDX_PERIPH_FLAGS:  next_state.flag = state.flag &
                                               !state.wdata[UNIT_FLAG_BIT];
          IDX_TIMER_LOW:     next_state.timer[7:0] = state.wdata[7:0];
          IDX_TIMER_HIGH:    next_state.timer[15:8] = state.wdata[7:0];
          IDX_TIMER_CONTROL: next_state.timer_ctl = state.wdata[5:0];
          IDX_CC_LOW:        next_state.cc_value[7:0] = state.wdata[7:0];
          IDX_CC_HIGH:       next_state.cc_value[15:8] = state.wdata[7:0];
          IDX_CC_CONTROL:    next_state.cc_ctl = state.wdata[5:0];
          IDX_PORT_C_DIR:    next_state.port_dir = state.wdata[7:0];
          IDX_PERIPH_IRQ_EN: next_state.unit_en = state.wdata[UNIT_EN_BIT];
          default:           next_state.port_data = state.port_data;
        endcase
      end

      // Read channel, answer one cycle after the address is taken
      if (state.rvalid && i_axi.rready)
      begin
        next_state.rvalid = 1'b0;
      end
      if (i_axi.arvalid && state.arready)
      begin
        next_state.rvalid = 1'b1;
        next_state.rdata  = {24'h000000,
                             read_byte(i_axi.araddr[9:2], state)};
        next_state.rresp  = mapped(i_axi.araddr[9:2]) ? RESP_OKAY
                                                      : RESP_SLVERR;
      end

      // Capture overwrites any unread value
      if (cap_evt)
      begin
        next_state.cc_value = state.timer;
      end

      // Compare match actions
      next_state.match_prev = is_compare &&
                              state.timer == state.cc_value;
      next_state.trigger    = 1'b0;
      if (match_evt)
      begin
        unique case (mode)
          MODE_CMP_HIGH:    next_state.cmp_latch = 1'b1;
          MODE_CMP_LOW:     next_state.cmp_latch = 1'b0;
          MODE_CMP_SOFT:    next_state.cmp_latch = state.cmp_latch;
          MODE_CMP_SPECIAL:
          begin
            next_state.timer   = 16'h0000;
            next_state.trigger = 1'b1;
          end
          default:          next_state.cmp_latch = state.cmp_latch;
        endcase
      end
      if (wr_ctl_zero)
      begin
        next_state.cmp_latch = 1'b0;
      end

      // Sticky flag, a new event wins over the clear
      if (cap_evt || match_evt)
      begin
        next_state.flag = 1'b1;
      end
    end

    // Ready and output flops follow the next values
    next_state.awready = !next_state.aw_held && !next_state.bvalid;
    next_state.wready  = !next_state.w_held && !next_state.bvalid;
    next_state.arready = !next_state.rvalid;
    next_state.irq     = next_state.flag && next_state.unit_en &&
                         next_state.periph_gate &&
                         next_state.global_en;
    next_state.pin_oe_n = next_state.port_dir[PIN_BIT];
    next_state.pin_out  = (next_state.cc_ctl[3:2] == 2'h2)
                          ? next_state.cmp_latch
                          : next_state.port_data[PIN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state          <= '0;
      state.port_dir <= PORT_C_DIR_RESET;
      state.pin_oe_n <= PORT_C_DIR_RESET[PIN_BIT];
      state.cc_ctl   <= CC_CONTROL_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from state
  assign o_axi = '{awready: state.awready, wready: state.wready,
                   bvalid: state.bvalid, bresp: state.bresp,
                   arready: state.arready, rvalid: state.rvalid,
                   rdata: state.rdata, rresp: state.rresp};
  assign o_pin_out     = state.pin_out;
  assign o_pin_oe_n    = state.pin_oe_n;
  assign o_irq         = state.irq;
  assign o_adc_trigger = state.trigger;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_capture;
    i_ce && cap_evt;
  endsequence

  sequence s_special_match;
    i_ce && match_evt && mode == MODE_CMP_SPECIAL;
  endsequence

  property p_capture_latch;
    s_capture |=> state.cc_value == $past(state.timer);
  endproperty
  a_capture_latch: assert property (p_capture_latch)
    else $error("capture did not copy timer count");

  property p_overwrite;
    s_capture ##[1:64] s_capture |=> state.cc_value == $past(state.timer);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("second capture did not overwrite");

  property p_flag_set;
    i_ce && (cap_evt || match_evt) |=> state.flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set unit flag");

  property p_irq_enable;
    o_irq |-> state.flag && state.unit_en && state.global_en;
  endproperty
  a_irq_enable: assert property (p_irq_enable)
    else $error("interrupt without enabled flag");

  property p_irq_gate;
    !state.periph_gate |-> !o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt passed a closed peripheral gate");

  property p_ctl_zero;
    i_ce && wr_ctl_zero |=> !state.cmp_latch ##1 !o_pin_out || !is_compare;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("zero control write left latch high");

  property p_drive_high;
    i_ce && match_evt && mode == MODE_CMP_HIGH && !wr_ctl_zero
      |=> state.cmp_latch;
  endproperty
  a_drive_high: assert property (p_drive_high)
    else $error("set-high match did not raise latch");

  property p_soft_only;
    i_ce && match_evt && mode == MODE_CMP_SOFT && !wr_ctl_zero
      |=> $stable(state.cmp_latch) && state.flag;
  endproperty
  a_soft_only: assert property (p_soft_only)
    else $error("soft compare touched the pin latch");

  property p_special;
    s_special_match |=> state.timer == 16'h0000 && o_adc_trigger
      ##1 !o_adc_trigger;
  endproperty
  a_special: assert property (p_special)
    else $error("special trigger did not reset timer or pulse");

endmodule : capture_compare_unit

// *** src/ccu_pkg.sv ***
// Constants, register map and bus carriers for the capture/compare unit
// Assumes a 32-bit AXI4-Lite master; byte address is four times the index
package ccu_pkg;

  // Bus widths and answers
  localparam int          AXI_AW      = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Register indices, byte address = index * 4
  localparam logic [7:0] IDX_PORT_C_DATA   = 8'h07;
  localparam logic [7:0] IDX_INT_CONTROL   = 8'h0B;
  localparam logic [7:0] IDX_PERIPH_FLAGS  = 8'h0C;
  localparam logic [7:0] IDX_TIMER_LOW     = 8'h0E;
  localparam logic [7:0] IDX_TIMER_HIGH    = 8'h0F;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] IDX_CC_LOW        = 8'h15;
  localparam logic [7:0] IDX_CC_HIGH       = 8'h16;
  localparam logic [7:0] IDX_CC_CONTROL    = 8'h17;
  localparam logic [7:0] IDX_PORT_C_DIR    = 8'h87;
  localparam logic [7:0] IDX_PERIPH_IRQ_EN = 8'h8C;

  // Field positions
  localparam int GLOBAL_IRQ_BIT   = 7;
  localparam int PERIPH_GATE_BIT  = 6;
  localparam int UNIT_FLAG_BIT    = 2;
  localparam int UNIT_EN_BIT      = 2;
  localparam int PIN_BIT          = 2;
  localparam int TIMER_ON_BIT     = 0;

  // Values after reset
  localparam logic [7:0] PORT_C_DIR_RESET = 8'hFF;
  localparam logic [5:0] CC_CONTROL_RESET = 6'h00;
  localparam logic [3:0] PRESCALE_RESET   = 4'h0;

  // Prescale terminal counts
  localparam logic [1:0] PRESCALE_4_LAST  = 2'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

  // Mode field encoding, all-zero is off
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH   = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW    = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT   = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

  // Capture event selection inside a capture mode
  typedef enum logic [1:0] {
    SEL_FALL,
    SEL_RISE,
    SEL_RISE4,
    SEL_RISE16
  } capture_sel_t;

  // Master to slave
  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } axi_req_t;

  // Slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

endpackage : ccu_pkg

// *** src/ccu_edge_detect.sv ***
// Edge detector on the effective pin level
// Assumes the level is synchronous to i_clk
`timescale 1ns/1ps
module ccu_edge_detect
  import ccu_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);

  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t state;
  edge_state_t next_state;

  // Compare level against last sample
  assign o_rise = i_level && !state.prev;
  assign o_fall = !i_level && state.prev;

  ////////////////////////////////////////////////////////////////////////////
  // Sample the level
  always_comb
  begin
    next_state = state;
    if (i_ce)
    begin
      next_state.prev = i_level;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule : ccu_edge_detect

// *** src/ccu_prescaler.sv ***
// Capture prescaler: picks the capture event from the pin edges
// Assumes edge pulses from ccu_edge_detect in the same clock domain
`timescale 1ns/1ps
module ccu_prescaler
  import ccu_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  input  wire logic         i_run,
  input  wire capture_sel_t i_sel,
  input  wire logic         i_rise,
  input  wire logic         i_fall,
  output logic              o_event
);

  typedef struct packed {
    logic [3:0] count;
  } pre_state_t;

  pre_state_t state;
  pre_state_t next_state;

  // Event selection by mode
  always_comb
  begin
    o_event = 1'b0;
    if (i_run)
    begin
      unique case (i_sel)
        SEL_FALL:   o_event = i_fall;
        SEL_RISE:   o_event = i_rise;
        SEL_RISE4:  o_event = i_rise &&
                              state.count[1:0] == PRESCALE_4_LAST;
        SEL_RISE16: o_event = i_rise &&
                              state.count == PRESCALE_16_LAST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count rising edges, cleared while not capturing
  always_comb
  begin
    next_state = state;
    if (i_ce)
    begin
      if (!i_run)
      begin
        next_state.count = PRESCALE_RESET;
      end
      else if (i_rise)
      begin
        next_state.count = state.count + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state.count <= PRESCALE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_clear_off;
    i_ce && !i_run |=> state.count == PRESCALE_RESET;
  endproperty
  a_clear_off: assert property (p_clear_off)
    else $error("prescaler not cleared outside capture");

  property p_tick_on_rise;
    o_event && i_sel != SEL_FALL |-> i_rise;
  endproperty
  a_tick_on_rise: assert property (p_tick_on_rise)
    else $error("rising capture event without rising edge");

  property p_keep_count;
    i_ce && i_run && !i_rise |=> $stable(state.count);
  endproperty
  a_keep_count: assert property (p_keep_count)
    else $error("prescaler count changed without edge");

endmodule : ccu_prescaler

// *** verification/pin_source.sv ***
// Partner on the capture/compare pin: external edge source
// Assumes the unit's oe_n is low while the unit drives the pin
`timescale 1ns/1ps
module pin_source
(
  input  wire logic i_level,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  output logic      o_pin
);
  // Resolved wire: the source drives only while the unit does not
  assign o_pin = i_pin_oe_n ? i_level : i_pin_out;
endmodule : pin_source

// *** verification/test_capture_compare_unit.sv ***
// Bench for the capture/compare unit: registers, capture, compare, irq
// Assumes ccu_pkg, pin_source and one 50 MHz clock
`timescale 1ns/1ps
module test_capture_compare_unit
  import ccu_pkg::*;
;
  typedef struct packed {
    logic       w;
    logic [7:0] idx;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
  } row_t;

  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       ce = 1'b1;
  logic       pin_cmd = 1'b0;
  logic       pin;
  logic       pin_out;
  logic       oe_n;
  logic       irq;
  logic       trig;
  axi_req_t   req = '{wstrb: 4'hF, default: '0};
  axi_rsp_t   rsp;
  logic [7:0] q;
  logic [1:0] r;
  int         miscompares = 0;
  int         checks_done = 0;
  logic [3:0] modes [4] = '{MODE_CAP_FALL, MODE_CAP_RISE,
                            MODE_CAP_RISE4, MODE_CAP_RISE16};
  int         cnt [4] = '{1, 1, 4, 16};
  row_t       regs [10] = '{
    '{1'b0, IDX_PORT_C_DIR, 8'h00, PORT_C_DIR_RESET, RESP_OKAY},
    '{1'b0, IDX_CC_CONTROL, 8'h00, 8'h00, RESP_OKAY},
    '{1'b0, IDX_PERIPH_FLAGS, 8'h00, 8'h00, RESP_OKAY},
    '{1'b0, IDX_PERIPH_IRQ_EN, 8'h00, 8'h00, RESP_OKAY},
    '{1'b1, 8'h20, 8'h55, 8'h00, RESP_SLVERR},
    '{1'b0, 8'h20, 8'h00, 8'h00, RESP_SLVERR},
    '{1'b1, IDX_PERIPH_IRQ_EN, 8'h04, 8'h00, RESP_OKAY},
    '{1'b0, IDX_PERIPH_IRQ_EN, 8'h00, 8'h04, RESP_OKAY},
    '{1'b1, IDX_INT_CONTROL, 8'hC0, 8'h00, RESP_OKAY},
    '{1'b0, IDX_INT_CONTROL, 8'h00, 8'hC0, RESP_OKAY}};

  // Clock and parts
  always #10 i_clk = ~i_clk;

  capture_compare_unit dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ce(ce), .i_axi(req), .o_axi(rsp), .i_pin_in(pin),
    .o_pin_out(pin_out), .o_pin_oe_n(oe_n), .o_irq(irq),
    .o_adc_trigger(trig));
  pin_source src_u (.i_level(pin_cmd), .i_pin_out(pin_out),
    .i_pin_oe_n(oe_n), .o_pin(pin));

  ////////////////////////////////////////////////////////////
  // Report, compare and bus tasks
  task automatic end_sim;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One AXI4-Lite transfer, held until each channel is taken
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    logic ta, tw, tr, dn;
    dn = 1'b0;
    req.awaddr <= {2'h0, idx, 2'h0};
    req.araddr <= {2'h0, idx, 2'h0};
    req.wdata <= {24'h000000, d};
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    for (int n = 0; n < 40 && !dn; n++)
    begin
      @(negedge i_clk);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      tr = req.arvalid & rsp.arready;
      dn = (req.bready & rsp.bvalid) | (req.rready & rsp.rvalid);
      q = rsp.rdata[7:0];
      r = w ? rsp.bresp : rsp.rresp;
      @(posedge i_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tr) req.arvalid <= 1'b0;
    end
    if (!dn) miscompares++;
    if (!dn) end_sim();
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    @(posedge i_clk);
  endtask : bus

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(q, e);
  endtask : rdc

  // Output select: 0 pin, 1 irq, 2 trigger, 3 oe_n
  function automatic logic [7:0] sig(input int s);
    logic [3:0] v;
    v = {oe_n, trig, irq, pin_out};
    return {7'h00, v[s]};
  endfunction : sig

  task automatic chk_now(input int s, input logic [7:0] e);
    @(negedge i_clk);
    chk(sig(s), e);
    @(posedge i_clk);
  endtask : chk_now

  task automatic wait_for(input int s);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 200 && !hit; n++)
    begin
      @(negedge i_clk);
      hit = sig(s) === 8'h01;
    end
    if (!hit) miscompares++;
    if (!hit) end_sim();
    @(posedge i_clk);
  endtask : wait_for

  task automatic pulse(input int k);
    repeat (k)
    begin
      pin_cmd <= 1'b1;
      repeat (2) @(posedge i_clk);
      pin_cmd <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask : pulse

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    chk_now(3, 8'h01);
    foreach (regs[i])
    begin
      bus(regs[i].w, regs[i].idx, regs[i].d);
      chk({6'h00, r}, {6'h00, regs[i].r});
      if (!regs[i].w) chk(q, regs[i].q);
    end
    // Capture events per mode, timer stopped at a known count
    foreach (modes[i])
    begin
      bus(1'b1, IDX_PERIPH_IRQ_EN, 8'h00);
      bus(1'b1, IDX_CC_CONTROL, 8'h00);
      bus(1'b1, IDX_CC_CONTROL, {4'h0, modes[i]});
      bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
      bus(1'b1, IDX_PERIPH_IRQ_EN, 8'h04);
      bus(1'b1, IDX_TIMER_HIGH, {modes[i], 4'h9});
      bus(1'b1, IDX_TIMER_LOW, 8'h3C);
      pulse(cnt[i] - 1);
      rdc(IDX_PERIPH_FLAGS, 8'h00);
      pulse(1);
      rdc(IDX_PERIPH_FLAGS, 8'h04);
      rdc(IDX_CC_LOW, 8'h3C);
      rdc(IDX_CC_HIGH, {modes[i], 4'h9});
      chk_now(1, 8'h01);
      bus(1'b1, IDX_PERIPH_IRQ_EN, 8'h00);
      chk_now(1, 8'h00);
      bus(1'b1, IDX_INT_CONTROL, 8'h80);
      bus(1'b1, IDX_PERIPH_IRQ_EN, 8'h04);
      chk_now(1, 8'h00);
      bus(1'b1, IDX_INT_CONTROL, 8'hC0);
      bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
      rdc(IDX_PERIPH_FLAGS, 8'h00);
    end
    // Overwrite of an unread capture
    bus(1'b1, IDX_CC_CONTROL, 8'h05);
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    rdc(IDX_PERIPH_FLAGS, 8'h00);
    bus(1'b1, IDX_TIMER_LOW, 8'h11);
    pulse(1);
    bus(1'b1, IDX_TIMER_LOW, 8'h22);
    pulse(1);
    rdc(IDX_CC_LOW, 8'h22);
    // Prescaler cleared by off, kept across a direct switch
    bus(1'b1, IDX_CC_CONTROL, 8'h06);
    pulse(3);
    bus(1'b1, IDX_CC_CONTROL, 8'h00);
    bus(1'b1, IDX_CC_CONTROL, 8'h06);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    pulse(3);
    rdc(IDX_PERIPH_FLAGS, 8'h00);
    pulse(1);
    rdc(IDX_PERIPH_FLAGS, 8'h04);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    pulse(3);
    bus(1'b1, IDX_CC_CONTROL, 8'h07);
    pulse(8);
    rdc(IDX_PERIPH_FLAGS, 8'h00);
    pulse(1);
    rdc(IDX_PERIPH_FLAGS, 8'h04);
    // Pin as output: a data write that changes it captures
    bus(1'b1, IDX_CC_CONTROL, 8'h00);
    bus(1'b1, IDX_CC_CONTROL, 8'h05);
    bus(1'b1, IDX_PORT_C_DIR, 8'hFB);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    bus(1'b1, IDX_TIMER_LOW, 8'h5A);
    bus(1'b1, IDX_PORT_C_DATA, 8'h04);
    rdc(IDX_PERIPH_FLAGS, 8'h04);
    rdc(IDX_CC_LOW, 8'h5A);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    ////////////////////////////////////////////////////////
    // Compare at 0x0010 with the timer running from zero
    bus(1'b1, IDX_CC_LOW, 8'h10);
    bus(1'b1, IDX_CC_HIGH, 8'h00);
    bus(1'b1, IDX_TIMER_LOW, 8'h00);
    bus(1'b1, IDX_TIMER_HIGH, 8'h00);
    bus(1'b1, IDX_CC_CONTROL, 8'h00);
    bus(1'b1, IDX_CC_CONTROL, 8'h08);
    bus(1'b1, IDX_TIMER_CONTROL, 8'h01);
    wait_for(0);
    rdc(IDX_PERIPH_FLAGS, 8'h04);
    bus(1'b1, IDX_CC_CONTROL, 8'h09);
    chk_now(0, 8'h01);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    bus(1'b1, IDX_TIMER_LOW, 8'h00);
    wait_for(1);
    chk_now(0, 8'h00);
    bus(1'b1, IDX_CC_CONTROL, 8'h08);
    bus(1'b1, IDX_TIMER_LOW, 8'h00);
    wait_for(0);
    bus(1'b1, IDX_CC_CONTROL, 8'h00);
    bus(1'b1, IDX_CC_CONTROL, 8'h0A);
    chk_now(0, 8'h00);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    bus(1'b1, IDX_TIMER_LOW, 8'h00);
    wait_for(1);
    chk_now(0, 8'h00);
    bus(1'b1, IDX_PERIPH_FLAGS, 8'h04);
    bus(1'b1, IDX_CC_CONTROL, 8'h0B);
    bus(1'b1, IDX_TIMER_LOW, 8'h00);
    wait_for(2);
    chk_now(2, 8'h00);
    rdc(IDX_TIMER_HIGH, 8'h00);
    bus(1'b0, IDX_TIMER_LOW, 8'h00);
    chk({7'h00, q < 8'h10}, 8'h01);
    // Reset in mid-run
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rdc(IDX_CC_CONTROL, 8'h00);
    rdc(IDX_PORT_C_DIR, PORT_C_DIR_RESET);
    chk_now(0, 8'h00);
    end_sim();
  end
endmodule : test_capture_compare_unit
